// >>> common/scss_map.svh
// scss_map.svh: numeric constants of the system clock source select block
// assumes inclusion by bare name from the package and the design modules
`ifndef SCSS_MAP_SVH
`define SCSS_MAP_SVH

// initial oscillator select encodings
`define SCSS_SEL_FRC 3'h0
`define SCSS_SEL_FRC_PLL 3'h1
`define SCSS_SEL_PRI 3'h2
`define SCSS_SEL_PRI_PLL 3'h3
`define SCSS_SEL_SEC 3'h4
`define SCSS_SEL_LOW_POWER_INTERNAL_RC 3'h5
`define SCSS_SEL_FRC_DIV16 3'h6
`define SCSS_SEL_FRC_DIV 3'h7

// primary oscillator mode encodings
`define SCSS_PMD_EXT 2'h0
`define SCSS_PMD_XT 2'h1
`define SCSS_PMD_HS 2'h2
`define SCSS_PMD_OFF 2'h3

// erased configuration word reads all ones
`define SCSS_SEL_ERASED 3'h7
`define SCSS_PMD_ERASED 2'h3

// postscale field value that gives the fixed divide by 16
`define SCSS_POST_DIV16 3'h3
`define SCSS_POST_RESET 3'h0

// timing
`define SCSS_MCLK_MHZ 100
`define SCSS_FCY_MAX_MHZ 40
`define SCSS_FCY_GAP ((`SCSS_MCLK_MHZ + `SCSS_FCY_MAX_MHZ - 1) / `SCSS_FCY_MAX_MHZ)
`define SCSS_HALVE 2
`define SCSS_MODE_COUNT 12

`endif

// >>> common/scss_pkg.sv
// scss_pkg: types of the system clock source select block
// assumes scss_map.svh is on the include path
package scss_pkg;
  `include "scss_map.svh"

  typedef enum logic [3:0] {
    SCSS_FRC = 4'h0,
    SCSS_FRC_PLL = 4'h1,
    SCSS_PRI_EXT = 4'h2,
    SCSS_PRI_XT = 4'h3,
    SCSS_PRI_HS = 4'h4,
    SCSS_PRI_EXT_PLL = 4'h5,
    SCSS_PRI_XT_PLL = 4'h6,
    SCSS_PRI_HS_PLL = 4'h7,
    SCSS_SEC = 4'h8,
    SCSS_LOW_POWER_INTERNAL_RC = 4'h9,
    SCSS_FRC_DIV16 = 4'ha,
    SCSS_FRC_DIV = 4'hb
  } scss_mode_t;

  // index of each oscillator input into the synchroniser vector
  typedef enum logic [2:0] {
    SCSS_SRC_FRC = 3'h0,
    SCSS_SRC_PRI = 3'h1,
    SCSS_SRC_SEC = 3'h2,
    SCSS_SRC_LOW_POWER_INTERNAL_RC = 3'h3,
    SCSS_SRC_PLL = 3'h4
  } scss_src_t;
endpackage

// >>> rtl/scss_edge_sync.sv
// scss_edge_sync: three-stage synchroniser and rising edge detector per bit
// assumes inputs are asynchronous square waves well below half of mclk
`timescale 1ns/10ps
module scss_edge_sync #(
  parameter int W = 5
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] rise
);
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic s1_q, s2_q, s3_q, lvl_q, lvl_d;
      // a change counts only once stages two and three agree
      always_comb begin
        lvl_d = lvl_q;
        if (s2_q == s3_q) begin
          lvl_d = s3_q;
        end
      end
      always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
          s3_q <= 1'b0;
          lvl_q <= 1'b0;
        end else begin
          s1_q <= async_in[i];
          s2_q <= s1_q;
          s3_q <= s2_q;
          lvl_q <= lvl_d;
        end
      end
      assign rise[i] = lvl_d & ~lvl_q;
    end
  endgenerate
endmodule // scss_edge_sync

// >>> rtl/scss_clock_select.sv
// scss_clock_select: picks the system clock source, postscales, halves to the
// instruction clock enable and forwards the low-power reference
// assumes oscillators arrive as asynchronous square waves sampled on mclk
//
// Notes on behaviour
// - seven clock options, fast rc, with pll, primary, primary pll, secondary, low_power_internal_rc, postscaled.
// - fast rc postscaler divides 1:2 up to 1:256 via three-bit field.
// - at power-on reset the source comes from the select and primary mode fields.
// - unprogrammed configuration starts from the fast internal rc oscillator.
// - configuration decodes into twelve distinct clock modes.
// - pll takes only fast rc or primary input; bypass feeds oscillator directly.
// - selected source or pll output is halved for instruction and peripheral clocks.
// - instruction clock never exceeds 40 MHz in any mode.
// - low-power rc feeds watchdog and fail-safe monitor regardless of selection.
// - primary oscillator supports medium crystal, high-speed crystal and external clock.
`timescale 1ns/10ps
`include "scss_map.svh"
module scss_clock_select (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic fast_internal_rc,
  input wire logic primary_osc_in_pin,
  input wire logic secondary_low_power_osc,
  input wire logic low_power_internal_rc,
  input wire logic pll_clk_in,
  input wire logic [2:0] initial_osc_select,
  input wire logic [1:0] primary_osc_mode_field,
  input wire logic [2:0] rc_postscale_field,
  output logic instruction_clock,
  output logic peripheral_time_base,
  output logic wdt_ref_tick,
  output logic fail_safe_ref_tick,
  output scss_pkg::scss_mode_t clock_mode,
  output logic pll_enable,
  output logic pll_src_primary,
  output logic crystal_amp_en
);
  import scss_pkg::*;

  localparam logic [1:0] GAP_LOAD = 2'(`SCSS_FCY_GAP - 1);

  ////////////////////////////////////////////////////////////////////////////
  // synchronise the oscillator inputs
  logic [4:0] rise;
  scss_edge_sync #(.W(5)) u_sync (
    .mclk(mclk),
    .reset_n(reset_n),
    .async_in({pll_clk_in, low_power_internal_rc, secondary_low_power_osc,
               primary_osc_in_pin, fast_internal_rc}),
    .rise(rise)
  );

  ////////////////////////////////////////////////////////////////////////////
  // configuration capture, once after reset release
  logic cfg_done_q, cfg_done_d;
  scss_mode_t mode_q, mode_d, mode_dec;
  logic cfg_erased;

  assign cfg_erased = (initial_osc_select == `SCSS_SEL_ERASED) &&
                      (primary_osc_mode_field == `SCSS_PMD_ERASED);

  always_comb begin
    mode_dec = SCSS_FRC;
    unique case (initial_osc_select)
      `SCSS_SEL_FRC: mode_dec = SCSS_FRC;
      `SCSS_SEL_FRC_PLL: mode_dec = SCSS_FRC_PLL;
      `SCSS_SEL_PRI, `SCSS_SEL_PRI_PLL: begin
        unique case (primary_osc_mode_field)
          `SCSS_PMD_EXT: mode_dec = initial_osc_select[0] ? SCSS_PRI_EXT_PLL : SCSS_PRI_EXT;
          `SCSS_PMD_XT: mode_dec = initial_osc_select[0] ? SCSS_PRI_XT_PLL : SCSS_PRI_XT;
          `SCSS_PMD_HS: mode_dec = initial_osc_select[0] ? SCSS_PRI_HS_PLL : SCSS_PRI_HS;
          // primary switched off: fall back so the core still gets a clock
          `SCSS_PMD_OFF: mode_dec = SCSS_FRC;
        endcase
      end
      `SCSS_SEL_SEC: mode_dec = SCSS_SEC;
      `SCSS_SEL_LOW_POWER_INTERNAL_RC: mode_dec = SCSS_LOW_POWER_INTERNAL_RC;
      `SCSS_SEL_FRC_DIV16: mode_dec = SCSS_FRC_DIV16;
      `SCSS_SEL_FRC_DIV: mode_dec = SCSS_FRC_DIV;
    endcase
    if (cfg_erased) begin
      mode_dec = SCSS_FRC;
    end
  end

  always_comb begin
    cfg_done_d = 1'b1;
    mode_d = mode_q;
    if (!cfg_done_q) begin
      mode_d = mode_dec;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_done_q <= 1'b0;
      mode_q <= SCSS_FRC;
    end else begin
      cfg_done_q <= cfg_done_d;
      mode_q <= mode_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // source selection, postscaler, pll routing
  logic is_pll, is_pri, is_div, src_tick, post_tick;
  logic [7:0] post_cnt_q, post_cnt_d, div_m1;
  logic [8:0] div_w;
  logic [2:0] post_sel;

  assign is_pll = (mode_q == SCSS_FRC_PLL) || (mode_q == SCSS_PRI_EXT_PLL) ||
                  (mode_q == SCSS_PRI_XT_PLL) || (mode_q == SCSS_PRI_HS_PLL);
  assign is_pri = (mode_q == SCSS_PRI_EXT) || (mode_q == SCSS_PRI_XT) ||
                  (mode_q == SCSS_PRI_HS);
  assign is_div = (mode_q == SCSS_FRC_DIV) || (mode_q == SCSS_FRC_DIV16);
  assign post_sel = (mode_q == SCSS_FRC_DIV16) ? `SCSS_POST_DIV16 : rc_postscale_field;
  assign div_w = 9'h001 << (4'(post_sel) + 4'h1);
  assign div_m1 = 8'(div_w - 9'h001);
  assign post_tick = rise[SCSS_SRC_FRC] && (post_cnt_q == div_m1);

  always_comb begin
    post_cnt_d = post_cnt_q;
    if (!is_div) begin
      post_cnt_d = 8'h00;
    end else if (rise[SCSS_SRC_FRC]) begin
      post_cnt_d = post_tick ? 8'h00 : 8'(post_cnt_q + 8'h01);
    end
    // field may shrink under a running count; restart rather than wrap 256
    if (is_div && (post_cnt_q > div_m1)) begin
      post_cnt_d = 8'h00;
    end
  end

  always_comb begin
    src_tick = 1'b0;
    if (is_pll) begin
      src_tick = rise[SCSS_SRC_PLL];
    end else if (is_pri) begin
      src_tick = rise[SCSS_SRC_PRI];
    end else if (is_div) begin
      src_tick = post_tick;
    end else if (mode_q == SCSS_SEC) begin
      src_tick = rise[SCSS_SRC_SEC];
    end else if (mode_q == SCSS_LOW_POWER_INTERNAL_RC) begin
      src_tick = rise[SCSS_SRC_LOW_POWER_INTERNAL_RC];
    end else begin
      src_tick = rise[SCSS_SRC_FRC];
    end
    if (!cfg_done_q) begin
      src_tick = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // halve to the instruction clock, with a rate guard
  logic half_q, half_d, fcy_d;
  logic [1:0] gap_q, gap_d;

  always_comb begin
    half_d = half_q;
    gap_d = (gap_q != 2'h0) ? 2'(gap_q - 2'h1) : 2'h0;
    fcy_d = 1'b0;
    if (src_tick) begin
      half_d = ~half_q;
      // a too-fast source loses pulses instead of overclocking the core
      if (half_q && (gap_q == 2'h0)) begin
        fcy_d = 1'b1;
        gap_d = GAP_LOAD;
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      post_cnt_q <= 8'h00;
      half_q <= 1'b0;
      gap_q <= 2'h0;
      instruction_clock <= 1'b0;
      peripheral_time_base <= 1'b0;
      wdt_ref_tick <= 1'b0;
      fail_safe_ref_tick <= 1'b0;
      clock_mode <= SCSS_FRC;
      pll_enable <= 1'b0;
      pll_src_primary <= 1'b0;
      crystal_amp_en <= 1'b0;
    end else begin
      post_cnt_q <= post_cnt_d;
      half_q <= half_d;
      gap_q <= gap_d;
      instruction_clock <= fcy_d;
      peripheral_time_base <= fcy_d;
      wdt_ref_tick <= rise[SCSS_SRC_LOW_POWER_INTERNAL_RC];
      fail_safe_ref_tick <= rise[SCSS_SRC_LOW_POWER_INTERNAL_RC];
      clock_mode <= mode_q;
      pll_enable <= is_pll;
      pll_src_primary <= is_pll && (mode_q != SCSS_FRC_PLL);
      crystal_amp_en <= (mode_q == SCSS_PRI_XT) || (mode_q == SCSS_PRI_HS) ||
                        (mode_q == SCSS_PRI_XT_PLL) || (mode_q == SCSS_PRI_HS_PLL);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  sequence s_fcy_burst;
    instruction_clock;
  endsequence
  sequence s_quiet2;
    !instruction_clock [*2];
  endsequence

  property p_fcy_gap;
    s_fcy_burst |=> s_quiet2;
  endproperty
  a_fcy_gap: assert property (p_fcy_gap) else $error("instruction clock above limit");

  property p_fp_same;
    instruction_clock == peripheral_time_base;
  endproperty
  a_fp_same: assert property (p_fp_same) else $error("time base differs");

  property p_halve;
    instruction_clock |-> $past(src_tick) && $past(half_q);
  endproperty
  a_halve: assert property (p_halve) else $error("fcy not from second tick");

  property p_low_power_internal_rc_ref;
    rise[SCSS_SRC_LOW_POWER_INTERNAL_RC] |=> wdt_ref_tick && fail_safe_ref_tick;
  endproperty
  a_low_power_internal_rc_ref: assert property (p_low_power_internal_rc_ref) else $error("low_power_internal_rc reference lost");

  property p_mode_hold;
    cfg_done_q |=> $stable(mode_q);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode changed after capture");

  property p_default;
    (!cfg_done_q && cfg_erased) |=> mode_q == SCSS_FRC;
  endproperty
  a_default: assert property (p_default) else $error("erased config not fast rc");

  property p_legal_mode;
    mode_q < 4'(`SCSS_MODE_COUNT);
  endproperty
  a_legal_mode: assert property (p_legal_mode) else $error("illegal clock mode");

  property p_pll_src;
    pll_enable |-> $past(mode_q) inside {SCSS_FRC_PLL, SCSS_PRI_EXT_PLL, SCSS_PRI_XT_PLL,
                                         SCSS_PRI_HS_PLL};
  endproperty
  a_pll_src: assert property (p_pll_src) else $error("pll enabled in bypass mode");

  // after the divide point the count must restart from zero
  property p_post_wrap;
    post_tick |=> post_cnt_q == 8'h00;
  endproperty
  a_post_wrap: assert property (p_post_wrap) else $error("postscaler wrap wrong");

  property p_post_div2;
    (is_div && post_sel == 3'h0 && rise[SCSS_SRC_FRC] && post_cnt_q == 8'h00) |-> !post_tick;
  endproperty
  a_post_div2: assert property (p_post_div2) else $error("divide by two fired early");

  property p_xtal;
    crystal_amp_en |-> $past(mode_q) != SCSS_PRI_EXT && $past(mode_q) != SCSS_PRI_EXT_PLL;
  endproperty
  a_xtal: assert property (p_xtal) else $error("crystal driver in external mode");
endmodule // scss_clock_select

// >>> testbench/testbench.sv
// testbench: self-checking bench for scss_clock_select
// assumes scss_pkg and scss_map.svh compiled first; one 100 MHz clock, no partner model
`timescale 1ns/10ps
module testbench;
  import scss_pkg::*;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic [4:0] osc = 5'h00;
  logic [2:0] sel_q = 3'h0;
  logic [1:0] pmd_q = 2'h0;
  logic [2:0] field_q = 3'h0;
  logic ic, ptb, wdt, fsm, pll_en, pll_pri, amp;
  scss_mode_t mode;
  int errors = 0;
  int checked = 0;
  int cycles = 0;
  int n_ic = 0;
  int n_wdt = 0;
  int n_fsm = 0;
  int gap = 0;

  always #5 mclk = ~mclk;

  scss_clock_select scss_clock_select_inst (
    .mclk(mclk), .reset_n(reset_n),
    .fast_internal_rc(osc[0]), .primary_osc_in_pin(osc[1]),
    .secondary_low_power_osc(osc[2]), .low_power_internal_rc(osc[3]),
    .pll_clk_in(osc[4]), .initial_osc_select(sel_q),
    .primary_osc_mode_field(pmd_q), .rc_postscale_field(field_q),
    .instruction_clock(ic), .peripheral_time_base(ptb),
    .wdt_ref_tick(wdt), .fail_safe_ref_tick(fsm), .clock_mode(mode),
    .pll_enable(pll_en), .pll_src_primary(pll_pri), .crystal_amp_en(amp)
  );

  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // outputs are read before this edge's updates land, so the count is race free
  always @(posedge mclk) begin
    cycles++;
    if (ic === 1'b1) n_ic++;
    if (wdt === 1'b1) n_wdt++;
    if (fsm === 1'b1) n_fsm++;
    if (ic === 1'b1) begin
      // guard spacing is three cycles, so at least two quiet cycles between pulses
      check(gap >= 2, 1'b1);
      gap = 0;
    end else gap++;
    check(ptb, ic);
    if (cycles == 60000) begin
      errors++;
      wrap_up();
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // straps only count at the first edge after release, so each run resets
  task automatic start(input logic [2:0] s, input logic [1:0] p, input logic [2:0] f);
    @(posedge mclk);
    reset_n <= 1'b0;
    sel_q <= s;
    pmd_q <= p;
    field_q <= f;
    repeat (8) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (3) @(posedge mclk);
  endtask

  // half period of 3 cycles: the fastest rate the synchroniser is sure to see
  task automatic toggle(input int idx, input int n);
    repeat (2 * n) begin
      @(posedge mclk);
      osc[idx] <= ~osc[idx];
      repeat (2) @(posedge mclk);
    end
  endtask

  function automatic scss_mode_t exp_mode(input logic [2:0] s, input logic [1:0] p);
    case (s)
      3'h1: exp_mode = SCSS_FRC_PLL;
      3'h2: exp_mode = (p == 2'h3) ? SCSS_FRC : scss_mode_t'(4'h2 + 4'(p));
      3'h3: exp_mode = (p == 2'h3) ? SCSS_FRC : scss_mode_t'(4'h5 + 4'(p));
      3'h4: exp_mode = SCSS_SEC;
      3'h5: exp_mode = SCSS_LOW_POWER_INTERNAL_RC;
      3'h6: exp_mode = SCSS_FRC_DIV16;
      3'h7: exp_mode = (p == 2'h3) ? SCSS_FRC : SCSS_FRC_DIV;
      default: exp_mode = SCSS_FRC;
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  task automatic test_reset();
    repeat (4) @(posedge mclk);
    check({ic, ptb, wdt, fsm, pll_en, pll_pri, amp}, 7'h00);
    check(mode, SCSS_FRC);
    start(3'h7, 2'h3, 3'h0);
    check(mode, SCSS_FRC);
    sel_q <= 3'h3;
    pmd_q <= 2'h2;
    repeat (4) @(posedge mclk);
    check(mode, SCSS_FRC);
    $display("reset test done");
  endtask

  task automatic test_decode();
    scss_mode_t m;
    for (int i = 0; i < 32; i++) begin
      // primary selected but switched off falls back to the fast rc
      start(i[4:2], i[1:0], 3'h0);
      m = exp_mode(i[4:2], i[1:0]);
      check(mode, m);
      check(pll_en, m inside {SCSS_FRC_PLL, [SCSS_PRI_EXT_PLL:SCSS_PRI_HS_PLL]});
      check(pll_pri, m inside {[SCSS_PRI_EXT_PLL:SCSS_PRI_HS_PLL]});
      check(amp, m inside {SCSS_PRI_XT, SCSS_PRI_HS, SCSS_PRI_XT_PLL, SCSS_PRI_HS_PLL});
    end
    $display("decode test done");
  endtask

  task automatic test_sources();
    int src[8] = '{0, 4, 1, 4, 2, 3, 0, 0};
    int want[8] = '{16, 16, 16, 16, 16, 16, 1, 8};
    int b_ic;
    int b_wdt;
    int b_fs;
    for (int s = 0; s < 8; s++) begin
      for (int k = 0; k < 5; k++) begin
        start(s[2:0], 2'h2, 3'h0);
        b_ic = n_ic;
        b_wdt = n_wdt;
        b_fs = n_fsm;
        toggle(k, 32);
        repeat (10) @(posedge mclk);
        check(n_ic - b_ic, (k == src[s]) ? want[s] : 0);
        check(n_wdt - b_wdt, (k == 3) ? 32 : 0);
        check(n_fsm - b_fs, (k == 3) ? 32 : 0);
      end
    end
    $display("source test done");
  endtask

  task automatic test_postscale();
    int b;
    for (int f = 0; f < 8; f++) begin
      start(3'h7, 2'h1, f[2:0]);
      b = n_ic;
      toggle(0, 512);
      repeat (10) @(posedge mclk);
      check(n_ic - b, 128 >> f);
    end
    start(3'h2, 2'h0, 3'h0);
    b = n_ic;
    toggle(1, 32);
    repeat (10) @(posedge mclk);
    check(n_ic - b, 16);
    $display("postscale test done");
  endtask

  initial begin
    test_reset();
    test_decode();
    test_sources();
    test_postscale();
    wrap_up();
  end
endmodule // testbench
